// *** core/adc_seq_map.vh ***
// register map, field positions and timing counts of the converter control
`ifndef ADC_SEQ_MAP_VH
`define ADC_SEQ_MAP_VH

// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define ADDR_CONTROL_STATUS 16'h1030
`define ADDR_RESULT_1       16'h1034
`define ADDR_RESULT_2       16'h1038
`define ADDR_RESULT_3       16'h103c
`define ADDR_RESULT_4       16'h1040
`define ADDR_OPTION         16'h1044

// ---------------------------------------------------------------
// control/status fields
// ---------------------------------------------------------------
`define CTL_FLAG_BIT   7
`define CTL_ZERO_BIT   6
`define CTL_SCAN_BIT   5
`define CTL_GROUP_BIT  4
`define CTL_SEL_HI     3
`define CTL_SEL_LO     0

// ---------------------------------------------------------------
// option fields and reset value
// ---------------------------------------------------------------
`define OPT_POWER_BIT  7
`define OPT_RC_BIT     6
`define OPT_RESET      2'h0

// ---------------------------------------------------------------
// channel codes
// ---------------------------------------------------------------
`define CHAN_HIGH_REF  4'hc
`define CHAN_LOW_REF   4'hd
`define CHAN_HALF_REF  4'he

// ---------------------------------------------------------------
// sequencer timing in conversion clocks; SYNC_CYCLES counts system clocks
// ---------------------------------------------------------------
`define CNT_SAMPLE_FIRST 6'h02
`define SAMPLE_CYCLES    6'h0c
`define CNT_SAMPLE_LAST  (`CNT_SAMPLE_FIRST + `SAMPLE_CYCLES - 6'h01)
`define CNT_SAR_FIRST    (`CNT_SAMPLE_LAST + 6'h01)
`define CNT_SAR_LAST     (`CNT_SAR_FIRST + 6'h07)
`define CNT_CONV_LAST    6'h21
`define SYNC_CYCLES      3'h3

`endif

// *** core/adc_sequence_control.v ***
// apb-mapped sequencer for an 8-bit successive-approximation converter
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "adc_seq_map.vh"

module adc_sequence_control (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [15:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        comparator_out,
  input  wire        rc_osc_tick,
  output reg  [3:0]  mux_channel,
  output reg         sample_enable,
  output reg         half_ref_sample,
  output reg  [7:0]  dac_code,
  output reg         charge_pump_enable,
  output reg         rc_clock_select,
  output reg         sequence_busy
);

  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_CONV = 2'h1;
  localparam [1:0] ST_SYNC = 2'h2;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // channel of conversion slot idx
  function [3:0] chan_of;
    input [3:0] sel;
    input       group;
    input [1:0] idx;
    begin
      chan_of = group ? {sel[3:2], idx} : sel;
    end
  endfunction

  // true when a channel code selects the half-reference test source
  function is_half;
    input [3:0] chan;
    begin
      is_half = (chan == `CHAN_HALF_REF);
    end
  endfunction

  // one successive-approximation decision at bit b
  function [7:0] sar_step;
    input [7:0] code;
    input [2:0] b;
    input       keep;
    reg   [7:0] t;
    begin
      t = code;
      if (!keep) begin
        t[b] = 1'b0;
      end
      if (b != 3'h0) begin
        t[b - 3'h1] = 1'b1;
      end
      sar_step = t;
    end
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  reg  [5:0] ctl_bits;
  reg        complete_flag;
  reg  [1:0] state;
  reg  [5:0] cnt;
  reg  [1:0] idx;
  reg  [2:0] sync_cnt;
  reg  [7:0] result_mem [0:3];

  wire       access     = psel & penable & pready;
  wire       ctl_write  = access & pwrite &
                          (paddr == `ADDR_CONTROL_STATUS);
  wire       opt_write  = access & pwrite & (paddr == `ADDR_OPTION);
  wire       scan       = ctl_bits[`CTL_SCAN_BIT];
  wire       group      = ctl_bits[`CTL_GROUP_BIT];
  wire [3:0] sel        = ctl_bits[`CTL_SEL_HI:`CTL_SEL_LO];
  wire       tick       = rc_clock_select ? rc_osc_tick : 1'b1;
  wire [5:0] next_cnt   = cnt + 6'h01;
  wire       conv_end   = (state == ST_CONV) & tick &
                          (cnt == `CNT_CONV_LAST);
  wire       do_store   = (conv_end & ~rc_clock_select) |
                          ((state == ST_SYNC) &
                           (sync_cnt == `SYNC_CYCLES));
  wire [1:0] next_idx   = idx + 2'h1;
  wire [5:0] sar_off    = cnt - `CNT_SAR_FIRST;
  wire [2:0] sar_bit    = 3'h7 - sar_off[2:0];
  wire       in_sample  = (next_cnt >= `CNT_SAMPLE_FIRST) &&
                          (next_cnt <= `CNT_SAMPLE_LAST);

  // ---------------------------------------------------------------
  // sequencer decode
  // ---------------------------------------------------------------
  wire       conv_tick  = (state == ST_CONV) & tick;
  wire       sar_window = (cnt >= `CNT_SAR_FIRST) &&
                          (cnt <= `CNT_SAR_LAST);
  wire       last_slot  = (idx == 2'h3);
  wire       stop_now   = do_store & last_slot & ~scan;
  wire [3:0] next_chan  = chan_of(sel, group, next_idx);
  wire [3:0] first_chan = chan_of(pwdata[3:0], pwdata[`CTL_GROUP_BIT],
                                  2'h0);
  wire       next_half  = is_half(next_chan);
  wire       cur_half   = is_half(mux_channel);

  // ---------------------------------------------------------------
  // read multiplexer
  // ---------------------------------------------------------------
  reg  [7:0] rd_byte;
  reg        rd_err;

  always @* begin
    rd_byte = 8'h00;
    rd_err  = 1'b0;
    case (paddr)
      `ADDR_CONTROL_STATUS: begin
        rd_byte = {complete_flag, 1'b0, ctl_bits};
      end
      `ADDR_RESULT_1: begin
        rd_byte = result_mem[0];
      end
      `ADDR_RESULT_2: begin
        rd_byte = result_mem[1];
      end
      `ADDR_RESULT_3: begin
        rd_byte = result_mem[2];
      end
      `ADDR_RESULT_4: begin
        rd_byte = result_mem[3];
      end
      `ADDR_OPTION: begin
        rd_byte = {charge_pump_enable, rc_clock_select, 6'h00};
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel & ~penable) begin
        // read data latched at setup, so a later result update cannot tear it
        prdata  <= {24'h000000, rd_byte};
        pslverr <= rd_err;
      end
    end
  end

  // control bits are not touched by reset
  always @(posedge clk) begin
    if (ctl_write) begin
      ctl_bits <= pwdata[5:0];
    end
  end

  // ---------------------------------------------------------------
  // option register
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      {charge_pump_enable, rc_clock_select} <= `OPT_RESET;
    end else if (opt_write) begin
      charge_pump_enable <= pwdata[`OPT_POWER_BIT];
      rc_clock_select    <= pwdata[`OPT_RC_BIT];
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // a control write aborts anything running and restarts; it wins
  // over a store falling in the same cycle

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
    end else if (ctl_write) begin
      state <= ST_CONV;
    end else if (do_store) begin
      if (last_slot & ~scan) begin
        state <= ST_IDLE;
      end else begin
        state <= ST_CONV;
      end
    end else begin
      case (state)
        ST_IDLE: begin
          state <= ST_IDLE;
        end
        ST_CONV: begin
          if (conv_end) begin
            state <= ST_SYNC;
          end
        end
        ST_SYNC: begin
          state <= ST_SYNC;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // completion flag
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      complete_flag <= 1'b0;
    end else if (ctl_write) begin
      complete_flag <= 1'b0;
    end else if (do_store & last_slot) begin
      complete_flag <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // conversion clock counter
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      cnt <= 6'h00;
    end else if (ctl_write) begin
      cnt <= 6'h00;
    end else if (do_store) begin
      cnt <= `CNT_SAMPLE_FIRST;
    end else if (conv_tick & ~conv_end) begin
      cnt <= next_cnt;
    end
  end

  // ---------------------------------------------------------------
  // slot index
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      idx <= 2'h0;
    end else if (ctl_write) begin
      idx <= 2'h0;
    end else if (do_store) begin
      idx <= next_idx;
    end
  end

  // ---------------------------------------------------------------
  // oscillator synchronising delay
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      sync_cnt <= 3'h0;
    end else if (ctl_write | do_store) begin
      sync_cnt <= 3'h0;
    end else if (state == ST_SYNC) begin
      sync_cnt <= sync_cnt + 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // successive-approximation register
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      dac_code <= 8'h00;
    end else if (ctl_write) begin
      dac_code <= 8'h00;
    end else if (~do_store & conv_tick) begin
      if (cnt == `CNT_SAMPLE_LAST) begin
        dac_code <= 8'h80;
      end else if (sar_window) begin
        dac_code <= sar_step(dac_code, sar_bit,
                             comparator_out);
      end
    end
  end

  // ---------------------------------------------------------------
  // channel multiplexer
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      mux_channel <= 4'h0;
    end else if (ctl_write) begin
      mux_channel <= first_chan;
    end else if (do_store) begin
      mux_channel <= next_chan;
    end
  end

  // ---------------------------------------------------------------
  // sample phase
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      sample_enable <= 1'b0;
    end else if (ctl_write) begin
      sample_enable <= 1'b0;
    end else if (do_store) begin
      sample_enable <= ~(last_slot & ~scan);
    end else if (conv_tick) begin
      sample_enable <= in_sample & ~conv_end;
    end
  end

  // ---------------------------------------------------------------
  // half-reference dac hookup
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      half_ref_sample <= 1'b0;
    end else if (ctl_write) begin
      half_ref_sample <= 1'b0;
    end else if (do_store) begin
      half_ref_sample <= next_half & ~(last_slot & ~scan);
    end else if (conv_tick) begin
      half_ref_sample <= in_sample & ~conv_end & cur_half;
    end
  end

  // ---------------------------------------------------------------
  // busy indication
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      sequence_busy <= 1'b0;
    end else if (ctl_write) begin
      sequence_busy <= 1'b1;
    end else if (stop_now) begin
      sequence_busy <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // result registers
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (~sys_rst & ~ctl_write & do_store) begin
      result_mem[idx] <= dac_code;
    end
  end

endmodule // adc_sequence_control

// *** testbench/adc_seq_props.sv ***
// concurrent checks on the converter control ports
`timescale 1ns/1ps
`include "adc_seq_map.vh"
module adc_seq_props (
  input logic        clk,
  input logic        sys_rst,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [15:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic [3:0]  mux_channel,
  input logic        sample_enable,
  input logic        half_ref_sample,
  input logic [7:0]  dac_code,
  input logic        rc_clock_select,
  input logic        sequence_busy
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  wire acc = psel && penable && pready;
  wire wr_ctl = acc && pwrite && paddr == `ADDR_CONTROL_STATUS;
  wire rd_res = acc && !pwrite && paddr >= `ADDR_RESULT_1
                && paddr <= `ADDR_RESULT_4;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_ctl_write; wr_ctl; endsequence
  sequence s_busy_run; sequence_busy [*8]; endsequence
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  chk_half_ref: assert property (
    half_ref_sample == (sample_enable && mux_channel == `CHAN_HALF_REF))
    else $error("half reference hookup wrong");
  chk_busy_start: assert property (
    s_ctl_write |=> s_busy_run) else $error("busy not held after write");
  chk_sample_start: assert property (
    s_ctl_write ##0 !rc_clock_select |-> ##[1:4] sample_enable)
    else $error("no sampling");
  chk_dac_msb: assert property (
    $fell(sample_enable) && !rc_clock_select && !$past(wr_ctl)
    |-> dac_code == 8'h80) else $error("first trial not msb");
  chk_status_read: assert property (
    acc && !pwrite && paddr == `ADDR_CONTROL_STATUS
    |-> prdata[6] == 1'h0 && prdata[31:8] == 24'h0)
    else $error("status read bits wrong");
  chk_result_width: assert property (
    rd_res |-> prdata[31:8] == 24'h0) else $error("result too wide");
  chk_rc_select: assert property (
    acc && pwrite && paddr == `ADDR_OPTION
    |=> rc_clock_select == $past(pwdata[`OPT_RC_BIT]))
    else $error("clock select not taken");
  chk_idle_quiet: assert property (
    !sequence_busy && !wr_ctl |=> !sample_enable)
    else $error("sampling while idle");
endmodule // adc_seq_props
bind adc_sequence_control adc_seq_props chk_u (.clk, .sys_rst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .mux_channel,
  .sample_enable, .half_ref_sample, .dac_code, .rc_clock_select,
  .sequence_busy);

// *** testbench/test_adc_sequence_control.sv ***
// self-checking bench for the converter control
`timescale 1ns/1ps
`include "adc_seq_map.vh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  fails++; $display("[ERR] %0t got %h want %h", $time, a, e); end end
module test_adc_sequence_control;
  logic        clk = 1'h0, sys_rst = 1'h1, rc_osc_tick = 1'h0;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, comparator_out, busy, sample_enable;
  logic [3:0]  mux_channel;
  logic [7:0]  dac_code, ain [16];
  logic [32:0] expq [$];
  int          fails = 0, samples_checked = 0, seed = 32'h9b045ba0;
  int          i, g, k;
  bit          rc_on = 1'h0;
  // analog side: the comparator follows the selected channel's level
  assign comparator_out = ain[mux_channel] >= dac_code;
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) rc_osc_tick <= rc_on && !($random(seed) & 3);
  adc_sequence_control dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comparator_out(comparator_out), .rc_osc_tick(rc_osc_tick),
    .mux_channel(mux_channel), .sample_enable(sample_enable),
    .half_ref_sample(), .dac_code(dac_code), .charge_pump_enable(),
    .rc_clock_select(), .sequence_busy(busy));
  // ---------------------------------------------------------------
  // monitor and tasks
  // ---------------------------------------------------------------
  always @(posedge clk) begin : mon
    logic [32:0] e;
    if (pready && !pwrite && expq.size() > 0) begin
      e = expq.pop_front();
      `CHK({pslverr, prdata}, e)
    end
  end
  function automatic logic [32:0] v(input logic [7:0] d);
    return {25'h0, d};
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [15:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'h1;
    do begin @(posedge clk); n++; end while (!pready && n < 8);
    if (pready !== 1'h1) begin fails++; summarize(); end
    psel <= 1'h0; penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [32:0] e);
    expq.push_back(e);
    bus(1'h0, a, 8'h0);
  endtask
  task automatic wait_done();
    for (int n = 0; busy !== 1'h0; n++) begin
      if (n > 4000) begin fails++; summarize(); end
      @(posedge clk);
    end
  endtask
  task automatic rd_all(input logic [7:0] b, input logic grp);
    for (k = 0; k < 4; k++)
      rd(`ADDR_RESULT_1 + 16'(4 * k), v(ain[grp ? {b[3:2], 2'(k)} : b]));
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    for (i = 0; i < 16; i++) ain[i] = 8'($random(seed));
    repeat (12) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    bus(1'h1, `ADDR_OPTION, 8'h80);
    rd(`ADDR_OPTION, v(8'h80));
    bus(1'h1, `ADDR_CONTROL_STATUS, 8'h43);
    rd(`ADDR_CONTROL_STATUS, v(8'h03));
    repeat (30) @(posedge clk);
    rd(`ADDR_RESULT_1, v(ain[3]));
    wait_done();
    rd(`ADDR_CONTROL_STATUS, v(8'h83));
    rd_all(8'h03, 1'h0);
    sys_rst <= 1'h1;
    @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    rd(`ADDR_CONTROL_STATUS, v(8'h03));
    bus(1'h1, `ADDR_RESULT_1, 8'h5a);
    rd(`ADDR_RESULT_1, v(ain[3]));
    rd(16'h1050, {1'h1, 32'h0});
    for (g = 0; g < 4; g++) begin
      for (i = 0; i < 16; i++) ain[i] = 8'($random(seed));
      bus(1'h1, `ADDR_CONTROL_STATUS, 8'(8'h12 | (g << 2)));
      wait_done();
      rd_all(8'(g << 2), 1'h1);
    end
    bus(1'h1, `ADDR_CONTROL_STATUS, 8'h05);
    repeat (20) @(posedge clk);
    bus(1'h1, `ADDR_CONTROL_STATUS, 8'h06);
    rd(`ADDR_CONTROL_STATUS, v(8'h06));
    wait_done();
    rd_all(8'h06, 1'h0);
    bus(1'h1, `ADDR_CONTROL_STATUS, 8'h30);
    repeat (140) @(posedge clk);
    rd(`ADDR_CONTROL_STATUS, v(8'hb0));
    for (i = 0; i < 4; i++) ain[i] = 8'($random(seed));
    repeat (170) @(posedge clk);
    `CHK(busy, 1'h1)
    rd_all(8'h00, 1'h1);
    bus(1'h1, `ADDR_OPTION, 8'hc0);
    rc_on = 1'h1;
    bus(1'h1, `ADDR_CONTROL_STATUS, 8'h07);
    wait_done();
    rd(`ADDR_CONTROL_STATUS, v(8'h87));
    rd_all(8'h07, 1'h0);
    summarize();
  end
endmodule // test_adc_sequence_control
